// File: phcf_top.sv
// Per-port PHY control fields for the two copper ports of a switch.
// Assumes a byte-wide register port and PHY cores that act on the outputs.
//
// Behaviour
// - With negotiation off, speed and duplex come from the forced fields.
// - Forced duplex set means full, clear half, when negotiation off or failed.
// - Forced duplex loads from each port's duplex strap on the first clock after reset release.
// - Pause ability bit, default one, includes or drops pause from advertisement.
// - Four ability bits, default one, each include or drop one speed/duplex ability.
// - LED blanking drives both port LED pins high; clear restores normal LEDs.
// - Transmitter disable bit stops the port transmitter; reset value zero.
// - Writing one to the restart field restarts negotiation with the partner.
// - Far-end fault disable stops fault detection and fault pattern sending.
// - Power down bit places the port PHY in power down.
// - Setting the crossover disable bit turns off automatic MDI/MDI-X selection.
// - With auto crossover off, bit one picks forced MDI or forced MDI-X.
`timescale 1ns/100ps
module phcf_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Straps
   input wire logic port1_duplex_strap,
   input wire logic port2_duplex_strap,
   input wire logic port1_an_strap,
   input wire logic port2_an_strap,
   input wire logic port1_speed_strap,
   input wire logic port2_speed_strap,
   // PHY core status, index 0 is port 1
   input wire logic [1:0] an_done,
   input wire logic [1:0] an_failed,
   input wire logic [1:0] neg_speed_100,
   input wire logic [1:0] neg_full_duplex,
   input wire logic [1:0] auto_mdi_sel,
   input wire logic [1:0] led_one_in,
   input wire logic [1:0] led_zero_in,
   // PHY core controls
   output logic [1:0] an_enable,
   output logic [1:0][4:0] adv_ability,
   output logic [1:0] link_speed_100,
   output logic [1:0] link_full_duplex,
   output logic [1:0] tx_disable,
   output logic [1:0] an_restart,
   output logic [1:0] fef_detect_en,
   output logic [1:0] fef_tx_en,
   output logic [1:0] power_down,
   output logic [1:0] mdi_mode,
   // LED pins
   output logic [1:0] port_led_one,
   output logic [1:0] port_led_zero
);

   localparam int NP = phcf_pkg::NUM_PORTS;

   // Address decode used for both write and read paths
   function automatic logic [2:0] decode(input logic [7:0] addr);
      // Returns {hit, port, select B}
      logic [2:0] d;
      d = 3'h0;
      unique case (addr)
         phcf_pkg::P1_CTL_A_OFS: d = 3'h4;
         phcf_pkg::P1_CTL_B_OFS: d = 3'h5;
         phcf_pkg::P2_CTL_A_OFS: d = 3'h6;
         phcf_pkg::P2_CTL_B_OFS: d = 3'h7;
         default: d = 3'h0;
      endcase
      return d;
   endfunction : decode

   phcf_port_if pif[NP] ();

   logic [NP-1:0] strap_an;
   logic [NP-1:0] strap_speed;
   logic [NP-1:0] strap_duplex;
   logic [NP-1:0][7:0] ctl_a;
   logic [NP-1:0][7:0] ctl_b;
   logic [NP-1:0] restart_req;
   logic [2:0] wr_dec;
   logic [2:0] rd_dec;

   assign strap_an = {port2_an_strap, port1_an_strap};
   assign strap_speed = {port2_speed_strap, port1_speed_strap};
   assign strap_duplex = {port2_duplex_strap, port1_duplex_strap};
   assign wr_dec = decode(reg_addr);
   assign rd_dec = decode(reg_addr);

   // One register slice per port
   for (genvar p = 0; p < NP; p++) begin : g_port
      assign pif[p].wr_a = reg_wr & wr_dec[2] & (wr_dec[1] == 1'(p)) & ~wr_dec[0];
      assign pif[p].wr_b = reg_wr & wr_dec[2] & (wr_dec[1] == 1'(p)) & wr_dec[0];
      assign pif[p].wdata = reg_wdata;
      assign ctl_a[p] = pif[p].ctl_a;
      assign ctl_b[p] = pif[p].ctl_b;
      assign restart_req[p] = pif[p].restart_req;

      phcf_port_regs u_regs (
         .clk(clk),
         .rst_n(rst_n),
         .strap_an(strap_an[p]),
         .strap_speed(strap_speed[p]),
         .strap_duplex(strap_duplex[p]),
         .pif(pif[p])
      );
   end

   // Read path
   logic [7:0] next_reg_rdata;
   logic next_reg_rvalid;

   always_comb begin
      next_reg_rvalid = reg_rd;
      next_reg_rdata = reg_rdata;
      if (reg_rd) begin
         // Unmapped and port 3 addresses read as zero
         if (!rd_dec[2]) begin
            next_reg_rdata = phcf_pkg::RDATA_UNMAPPED;
         end else if (rd_dec[0]) begin
            next_reg_rdata = ctl_b[rd_dec[1]];
         end else begin
            next_reg_rdata = ctl_a[rd_dec[1]];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata <= next_reg_rdata;
         reg_rvalid <= next_reg_rvalid;
      end
   end

   // PHY control outputs
   logic [NP-1:0] next_an_enable;
   logic [NP-1:0][4:0] next_adv_ability;
   logic [NP-1:0] next_link_speed_100;
   logic [NP-1:0] next_link_full_duplex;
   logic [NP-1:0] next_tx_disable;
   logic [NP-1:0] next_an_restart;
   logic [NP-1:0] next_fef_detect_en;
   logic [NP-1:0] next_fef_tx_en;
   logic [NP-1:0] next_power_down;
   logic [NP-1:0] next_mdi_mode;
   logic [NP-1:0] next_port_led_one;
   logic [NP-1:0] next_port_led_zero;

   always_comb begin
      logic use_forced;
      use_forced = 1'b0;
      for (int p = 0; p < NP; p++) begin
         next_an_enable[p] = ctl_a[p][phcf_pkg::A_AN_EN];
         next_adv_ability[p] = ctl_a[p][phcf_pkg::A_ADV_PAUSE:phcf_pkg::A_ADV_10H];
         // Failed negotiation keeps the detected speed but the forced duplex
         use_forced = ~ctl_a[p][phcf_pkg::A_AN_EN];
         next_link_speed_100[p] = use_forced ? ctl_a[p][phcf_pkg::A_FSPEED]
                                             : neg_speed_100[p];
         if (use_forced | an_failed[p]) begin
            next_link_full_duplex[p] = ctl_a[p][phcf_pkg::A_FDUPLEX];
         end else begin
            next_link_full_duplex[p] = neg_full_duplex[p] & an_done[p];
         end
         next_tx_disable[p] = ctl_b[p][phcf_pkg::B_TX_DIS];
         next_an_restart[p] = restart_req[p];
         next_fef_detect_en[p] = ~ctl_b[p][phcf_pkg::B_FEF_DIS];
         next_fef_tx_en[p] = ~ctl_b[p][phcf_pkg::B_FEF_DIS];
         next_power_down[p] = ctl_b[p][phcf_pkg::B_PWR_DOWN];
         if (ctl_b[p][phcf_pkg::B_MDIX_DIS]) begin
            next_mdi_mode[p] = ctl_b[p][phcf_pkg::B_FORCE_MDI];
         end else begin
            next_mdi_mode[p] = auto_mdi_sel[p];
         end
         // Blanked LEDs are driven high, the off level of these pins
         next_port_led_one[p] = led_one_in[p] | ctl_b[p][phcf_pkg::B_LED_OFF];
         next_port_led_zero[p] = led_zero_in[p] | ctl_b[p][phcf_pkg::B_LED_OFF];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         an_enable <= '0;
         adv_ability <= {phcf_pkg::A_ADV_RST, phcf_pkg::A_ADV_RST};
         link_speed_100 <= '0;
         link_full_duplex <= '0;
         tx_disable <= '0;
         an_restart <= '0;
         fef_detect_en <= '1;
         fef_tx_en <= '1;
         power_down <= '0;
         mdi_mode <= '0;
         port_led_one <= '1;
         port_led_zero <= '1;
      end else begin
         an_enable <= next_an_enable;
         adv_ability <= next_adv_ability;
         link_speed_100 <= next_link_speed_100;
         link_full_duplex <= next_link_full_duplex;
         tx_disable <= next_tx_disable;
         an_restart <= next_an_restart;
         fef_detect_en <= next_fef_detect_en;
         fef_tx_en <= next_fef_tx_en;
         power_down <= next_power_down;
         mdi_mode <= next_mdi_mode;
         port_led_one <= next_port_led_one;
         port_led_zero <= next_port_led_zero;
      end
   end

endmodule : phcf_top

// File: phcf_pkg.sv
// Constants for the per-port PHY control fields of a two-PHY switch.
// Assumes 8-bit registers reached by a plain byte-wide register port.
package phcf_pkg;

   localparam int NUM_PORTS = 2;

   // Register offsets
   localparam logic [7:0] P1_CTL_A_OFS = 8'h1C;
   localparam logic [7:0] P1_CTL_B_OFS = 8'h1D;
   localparam logic [7:0] P2_CTL_A_OFS = 8'h2C;
   localparam logic [7:0] P2_CTL_B_OFS = 8'h2D;

   // Control A field positions
   localparam int A_AN_EN = 7;
   localparam int A_FSPEED = 6;
   localparam int A_FDUPLEX = 5;
   localparam int A_ADV_PAUSE = 4;
   localparam int A_ADV_100F = 3;
   localparam int A_ADV_100H = 2;
   localparam int A_ADV_10F = 1;
   localparam int A_ADV_10H = 0;

   // Control B field positions
   localparam int B_LED_OFF = 7;
   localparam int B_TX_DIS = 6;
   localparam int B_AN_RESTART = 5;
   localparam int B_FEF_DIS = 4;
   localparam int B_PWR_DOWN = 3;
   localparam int B_MDIX_DIS = 2;
   localparam int B_FORCE_MDI = 1;

   // Reset values; upper three A bits come from straps
   localparam logic [4:0] A_ADV_RST = 5'h1F;
   localparam logic [7:0] A_RST = 8'h1F;
   localparam logic [7:0] B_RST = 8'h00;

   // Writable bits of B; restart is a pulse, bit 0 belongs elsewhere
   localparam logic [7:0] B_WR_MASK = 8'hDE;

   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

endpackage : phcf_pkg

// File: phcf_port_if.sv
// Carries one port's register writes and stored fields between modules.
// Assumes a single clock domain; all signals are sampled on clk.
`timescale 1ns/100ps
interface phcf_port_if;
   logic wr_a;
   logic wr_b;
   logic [7:0] wdata;
   logic [7:0] ctl_a;
   logic [7:0] ctl_b;
   logic restart_req;

   modport regs (
      input wr_a,
      input wr_b,
      input wdata,
      output ctl_a,
      output ctl_b,
      output restart_req
   );

   modport ctrl (
      output wr_a,
      output wr_b,
      output wdata,
      input ctl_a,
      input ctl_b,
      input restart_req
   );
endinterface : phcf_port_if

// File: phcf_port_regs.sv
// Storage of the two control registers of one PHY port.
// Assumes straps are stable around reset release and sampled on clk.
`timescale 1ns/100ps
module phcf_port_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Straps
   input wire logic strap_an,
   input wire logic strap_speed,
   input wire logic strap_duplex,
   // Register side
   phcf_port_if.regs pif
);

   logic strap_done;
   logic [7:0] ctl_a;
   logic [7:0] ctl_b;
   logic next_strap_done;
   logic [7:0] next_ctl_a;
   logic [7:0] next_ctl_b;

   always_comb begin
      next_strap_done = 1'b1;
      next_ctl_a = ctl_a;
      next_ctl_b = ctl_b;
      // Straps taken by a clock after release, never by the async reset
      if (!strap_done) begin
         next_ctl_a = {strap_an, strap_speed, strap_duplex, phcf_pkg::A_ADV_RST};
      end else begin
         if (pif.wr_a) begin
            next_ctl_a = pif.wdata;
         end
         if (pif.wr_b) begin
            next_ctl_b = pif.wdata & phcf_pkg::B_WR_MASK;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_done <= 1'b0;
         ctl_a <= phcf_pkg::A_RST;
         ctl_b <= phcf_pkg::B_RST;
      end else begin
         strap_done <= next_strap_done;
         ctl_a <= next_ctl_a;
         ctl_b <= next_ctl_b;
      end
   end

   assign pif.ctl_a = ctl_a;
   assign pif.ctl_b = ctl_b;
   assign pif.restart_req = strap_done & pif.wr_b & pif.wdata[phcf_pkg::B_AN_RESTART];

endmodule : phcf_port_regs

// File: phcf_top_properties.sv
// Checker on the register port and the port control outputs.
// Assumes reads answer one edge on and fields reach outputs two edges on.
`timescale 1ns/100ps
module phcf_top_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_rvalid,
   // Controls
   input wire logic [1:0] an_restart,
   input wire logic [1:0] tx_disable,
   input wire logic [1:0] fef_detect_en,
   input wire logic [1:0] fef_tx_en,
   input wire logic [1:0] power_down,
   input wire logic [1:0] mdi_mode,
   input wire logic [1:0] port_led_one,
   input wire logic [1:0] port_led_zero
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_w1;
      reg_wr && reg_addr == 8'h1D;
   endsequence
   sequence s_w2;
      reg_wr && reg_addr == 8'h2D;
   endsequence
   property p_rv;
      reg_rd |=> reg_rvalid;
   endproperty
   property p_norv;
      !reg_rd |=> !reg_rvalid;
   endproperty
   property p_led;
      s_w1 ##0 reg_wdata[7] |-> ##2 port_led_one[0] && port_led_zero[0];
   endproperty
   property p_tx;
      s_w1 |-> ##2 tx_disable[0] == $past(reg_wdata[6], 2);
   endproperty
   property p_fef;
      s_w1 |-> ##2 fef_detect_en[0] != $past(reg_wdata[4], 2) && fef_tx_en[0] == fef_detect_en[0];
   endproperty
   property p_pd;
      s_w2 |-> ##2 power_down[1] == $past(reg_wdata[3], 2);
   endproperty
   property p_mdi;
      s_w2 ##0 reg_wdata[2] |-> ##2 mdi_mode[1] == $past(reg_wdata[1], 2);
   endproperty
   property p_rs;
      // A second restart write back to back legally stretches the pulse
      s_w2 ##0 reg_wdata[5] |=> an_restart[1] ##1
         an_restart[1] == $past(reg_wr && reg_addr == 8'h2D && reg_wdata[5]);
   endproperty
   a_rv: assert property (p_rv) else $error("no read answer");
   a_norv: assert property (p_norv) else $error("stray read answer");
   a_led: assert property (p_led) else $error("led not blanked");
   a_tx: assert property (p_tx) else $error("tx disable wrong");
   a_fef: assert property (p_fef) else $error("far-end fault wrong");
   a_pd: assert property (p_pd) else $error("power down wrong");
   a_mdi: assert property (p_mdi) else $error("forced crossover wrong");
   a_rs: assert property (p_rs) else $error("restart pulse wrong");
   c_rd: cover property (reg_rd ##1 reg_rvalid);
   c_rs: cover property (an_restart[1]);
   c_led: cover property (port_led_one[0]);
endmodule : phcf_top_properties

bind phcf_top phcf_top_properties u_phcf_top_properties (.clk, .rst_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rvalid, .an_restart, .tx_disable, .fef_detect_en, .fef_tx_en,
   .power_down, .mdi_mode, .port_led_one, .port_led_zero);

// File: phcf_link_partner.sv
// Far-side stand-in: PHY core status and raw LED levels for both ports.
// Assumes the bench commands negotiation failure; done drops after restart.
`timescale 1ns/100ps
module phcf_link_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Commands
   input wire logic [1:0] an_restart,
   input wire logic [1:0] fail,
   // Status
   output logic [1:0] an_done,
   output logic [1:0] an_failed,
   output logic [1:0] neg_speed_100,
   output logic [1:0] neg_full_duplex,
   output logic [1:0] auto_mdi_sel,
   output logic [1:0] led_one_in,
   output logic [1:0] led_zero_in
);
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   always_comb begin
      next_cnt = (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
      if (|an_restart) begin
         next_cnt = 4'h8;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
      end else begin
         cnt <= next_cnt;
      end
   end
   // Slow renegotiation, so done really drops
   assign an_done = (cnt == 4'h0) ? 2'h3 : 2'h0;
   assign an_failed = fail;
   assign neg_speed_100 = 2'h2;
   assign neg_full_duplex = 2'h0;
   assign auto_mdi_sel = 2'h1;
   // LEDs lit, so blanking shows
   assign led_one_in = 2'h0;
   assign led_zero_in = 2'h0;
endmodule : phcf_link_partner

// File: tb_phcf_top.sv
// Testbench for the port control fields: register tasks and port checks.
// Assumes the link partner model drives the PHY core status inputs.
`timescale 1ns/100ps
module tb_phcf_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic port1_duplex_strap = 1'b1;
   logic port2_duplex_strap = 1'b0;
   logic port1_an_strap = 1'b0;
   logic port2_an_strap = 1'b0;
   logic port1_speed_strap = 1'b1;
   logic port2_speed_strap = 1'b0;
   logic [1:0] fail = 2'h0;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic [1:0] an_done, an_failed, neg_speed_100, neg_full_duplex, auto_mdi_sel;
   logic [1:0] led_one_in, led_zero_in, an_enable, link_speed_100, link_full_duplex;
   logic [1:0] tx_disable, an_restart, fef_detect_en, fef_tx_en, power_down, mdi_mode;
   logic [1:0] port_led_one, port_led_zero;
   logic [1:0][4:0] adv_ability;
   logic [7:0] v;
   int n_errors = 0;
   int num_checks = 0;
   int npulse = 0;
   always #2 clk = ~clk;
   // Counted mid-cycle, away from the edge that launches the pulse
   always @(negedge clk) if (an_restart[1] === 1'b1) npulse++;
   phcf_top u_phcf_top (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .reg_rvalid, .port1_duplex_strap, .port2_duplex_strap, .port1_an_strap, .port2_an_strap,
      .port1_speed_strap, .port2_speed_strap, .an_done, .an_failed, .neg_speed_100,
      .neg_full_duplex, .auto_mdi_sel, .led_one_in, .led_zero_in, .an_enable, .adv_ability,
      .link_speed_100, .link_full_duplex, .tx_disable, .an_restart, .fef_detect_en, .fef_tx_en,
      .power_down, .mdi_mode, .port_led_one, .port_led_zero);
   phcf_link_partner u_phcf_link_partner (.clk, .rst_n, .an_restart, .fail, .an_done,
      .an_failed, .neg_speed_100, .neg_full_duplex, .auto_mdi_sel, .led_one_in, .led_zero_in);
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk("rvalid", 8'h01, {7'h00, reg_rvalid});
      chk("rdata", e, reg_rdata);
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #20000;
      n_errors++;
      wrap_up();
   end
   initial begin
      cyc(5);
      rst_n = 1'b1;
      cyc(2);
      rd(8'h1C, 8'h7F);
      rd(8'h2C, 8'h1F);
      rd(8'h1D, 8'h00);
      chk("duplex", 8'h01, {6'h00, link_full_duplex});
      chk("speed", 8'h01, {6'h00, link_speed_100});
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         v = 8'h60 | (8'h1F ^ (8'h01 << i));
         wr(8'h1C, v);
         rd(8'h1C, v);
         cyc(2);
         chk("adv", {3'h0, v[4:0]}, {3'h0, adv_ability[0]});
      end
      $display("test advertise done");
      wr(8'h1C, 8'h00);
      cyc(3);
      chk("forced", 8'h00, {6'h00, link_speed_100[0], link_full_duplex[0]});
      fail = 2'h2;
      wr(8'h2C, 8'hA0);
      cyc(3);
      chk("failed", 8'h03, {6'h00, link_speed_100[1], link_full_duplex[1]});
      fail = 2'h0;
      cyc(3);
      chk("negotiated", 8'h02, {6'h00, link_speed_100[1], link_full_duplex[1]});
      $display("test duplex done");
      wr(8'h1D, 8'hDE);
      rd(8'h1D, 8'hDE);
      cyc(2);
      v = {1'b0, port_led_one[0], port_led_zero[0], tx_disable[0], fef_detect_en[0],
         fef_tx_en[0], power_down[0], mdi_mode[0]};
      chk("ctl_b set", 8'h73, v);
      wr(8'h1D, 8'h04);
      cyc(3);
      v = {1'b0, port_led_one[0], port_led_zero[0], tx_disable[0], fef_detect_en[0],
         fef_tx_en[0], power_down[0], mdi_mode[0]};
      chk("ctl_b clear", 8'h0C, v);
      wr(8'h2D, 8'h06);
      cyc(3);
      chk("mdi", 8'h01, {7'h00, mdi_mode[1]});
      wr(8'h2D, 8'h20);
      rd(8'h2D, 8'h00);
      cyc(3);
      chk("restarts", 8'h01, npulse[7:0]);
      wr(8'h3D, 8'hFF);
      rd(8'h3D, 8'h00);
      rd(8'h2D, 8'h00);
      $display("test control done");
      rst_n = 1'b0;
      port1_duplex_strap = 1'b0;
      port2_an_strap = 1'b1;
      cyc(5);
      rst_n = 1'b1;
      cyc(2);
      rd(8'h1C, 8'h5F);
      rd(8'h2C, 8'h9F);
      chk("an_enable", 8'h02, {6'h00, an_enable});
      chk("adv2", 8'h1F, {3'h0, adv_ability[1]});
      chk("led2 lit", 8'h00, {6'h00, port_led_one[1], port_led_zero[1]});
      wr(8'h2D, 8'h80);
      cyc(3);
      chk("led2 off", 8'h03, {6'h00, port_led_one[1], port_led_zero[1]});
      $display("test restrap done");
      wrap_up();
   end
endmodule : tb_phcf_top
